// ===== hdl/instr_exec_pkg.sv
// Shared types and constants for the table read / xor instruction executor
package instr_exec_pkg;

   localparam int unsigned DATA_W = 8;
   localparam int unsigned ROM_W = 14;
   localparam int unsigned ROM_ADDR_W = 11;
   localparam int unsigned REG_ADDR_W = 7;
   localparam int unsigned PTR_LSB_W = 3;
   localparam int unsigned HIGH_W = 6;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [5:0] HIGH_DATA_RESET = 6'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [2:0] TABLE_READ_CYCLES = 3'h2;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_TABLE_READ,
      OP_TIMER_MODE_READ,
      OP_XOR_REG,
      OP_XOR_IMM
   } opcode_t;

   // One decoded instruction from the core
   typedef struct packed {
      logic valid;
      opcode_t op;
      logic [6:0] reg_addr;
      logic dest_reg;
      logic [7:0] imm;
   } instr_t;

   // Write-back to the data-memory register file
   typedef struct packed {
      logic en;
      logic [6:0] addr;
      logic [7:0] data;
   } reg_wr_t;

endpackage : instr_exec_pkg

// ===== hdl/table_read_xor_instr_exec.sv
// Executes table read, timer mode read and exclusive-OR instructions
`timescale 1ns/1ns

// What this block does
// - Table read addresses ROM by {pointer[2:0], accumulator}; low byte goes to accumulator.
// - Table read places upper six ROM word bits into table high data [5:0].
// - Timer mode read copies timer0 mode register to accumulator; flags unchanged.
// - Register XOR combines accumulator with register 0..127 and updates zero flag.
// - Register XOR destination 0 writes accumulator, destination 1 writes the register.
// - Immediate XOR combines accumulator with 8-bit immediate, into accumulator, updates zero.
module table_read_xor_instr_exec (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Decoded instruction
   input wire instr_exec_pkg::instr_t instr_i,
   output logic busy_o,
   // Core state inputs
   input wire logic [2:0] table_high_pointer_i,
   input wire logic [7:0] timer0_mode_reg_i,
   input wire logic [7:0] reg_rdata_i,
   // Program memory, word expected in the same cycle the address is presented
   output logic rom_rd_o,
   output logic [10:0] rom_addr_o,
   input wire logic [13:0] rom_data_i,
   // Register file access
   output logic [6:0] reg_raddr_o,
   output instr_exec_pkg::reg_wr_t reg_wr_o,
   // Architectural results
   output logic [7:0] accumulator_o,
   output logic [5:0] table_high_data_o,
   output logic zero_flag_o,
   output logic zero_flag_wr_o
);

   typedef enum logic {ST_IDLE, ST_ROM_WAIT} state_t;

   state_t state_q, state_d;
   logic [7:0] acc_q, acc_d;
   logic [5:0] thd_q, thd_d;
   logic zf_q, zf_d;
   logic zf_wr_q, zf_wr_d;
   logic rom_rd_q, rom_rd_d;
   logic busy_q, busy_d;
   logic [10:0] rom_addr_q, rom_addr_d;
   instr_exec_pkg::reg_wr_t wr_q, wr_d;
   logic [7:0] xor_b;
   logic [7:0] xor_res;
   logic xor_zero;

   // The register operand is read combinationally from the file
   assign reg_raddr_o = instr_i.reg_addr;
   assign xor_b = (instr_i.op == instr_exec_pkg::OP_XOR_IMM) ? instr_i.imm : reg_rdata_i;

   xor_unit u_xor (
      .a_i(acc_q),
      .b_i(xor_b),
      .result_o(xor_res),
      .zero_o(xor_zero)
   );

   always_comb begin
      state_d = state_q;
      acc_d = acc_q;
      thd_d = thd_q;
      zf_d = zf_q;
      zf_wr_d = 1'b0;
      rom_rd_d = 1'b0;
      busy_d = 1'b0;
      rom_addr_d = rom_addr_q;
      wr_d = '0;
      case (state_q)
         ST_IDLE: begin
            if (instr_i.valid) begin
               case (instr_i.op)
                  instr_exec_pkg::OP_TABLE_READ: begin
                     rom_addr_d = {table_high_pointer_i, acc_q};
                     rom_rd_d = 1'b1;
                     busy_d = 1'b1;
                     state_d = ST_ROM_WAIT;
                  end
                  instr_exec_pkg::OP_TIMER_MODE_READ: begin
                     acc_d = timer0_mode_reg_i;
                  end
                  instr_exec_pkg::OP_XOR_REG: begin
                     if (instr_i.dest_reg) begin
                        wr_d.en = 1'b1;
                        wr_d.addr = instr_i.reg_addr;
                        wr_d.data = xor_res;
                     end else begin
                        acc_d = xor_res;
                     end
                     zf_d = xor_zero;
                     zf_wr_d = 1'b1;
                  end
                  instr_exec_pkg::OP_XOR_IMM: begin
                     acc_d = xor_res;
                     zf_d = xor_zero;
                     zf_wr_d = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_ROM_WAIT: begin
            acc_d = rom_data_i[7:0];
            thd_d = rom_data_i[13:8];
            state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ST_IDLE;
         acc_q <= instr_exec_pkg::ACC_RESET;
         thd_q <= instr_exec_pkg::HIGH_DATA_RESET;
         zf_q <= 1'b0;
         zf_wr_q <= 1'b0;
         rom_rd_q <= 1'b0;
         busy_q <= 1'b0;
         rom_addr_q <= '0;
         wr_q <= '0;
      end else begin
         state_q <= state_d;
         acc_q <= acc_d;
         thd_q <= thd_d;
         zf_q <= zf_d;
         zf_wr_q <= zf_wr_d;
         rom_rd_q <= rom_rd_d;
         busy_q <= busy_d;
         rom_addr_q <= rom_addr_d;
         wr_q <= wr_d;
      end
   end

   // Busy covers the second cycle of the two-cycle table read; its own flop keeps the output glitch free
   assign busy_o = busy_q;
   assign rom_rd_o = rom_rd_q;
   assign rom_addr_o = rom_addr_q;
   assign reg_wr_o = wr_q;
   assign accumulator_o = acc_q;
   assign table_high_data_o = thd_q;
   assign zero_flag_o = zf_q;
   assign zero_flag_wr_o = zf_wr_q;

   // Assertions
   sequence s_table_issue;
      state_q == ST_IDLE && instr_i.valid && instr_i.op == instr_exec_pkg::OP_TABLE_READ;
   endsequence

   chk_table_addr: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      s_table_issue |=> rom_rd_o && rom_addr_o == {$past(table_high_pointer_i), $past(acc_q)})
      else $error("table read address wrong");

   chk_table_low: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      s_table_issue ##1 1'b1 |=> accumulator_o == $past(rom_data_i[7:0]))
      else $error("table read low byte wrong");

   chk_table_high: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      s_table_issue ##1 1'b1 |=> table_high_data_o == $past(rom_data_i[13:8]))
      else $error("table read high bits wrong");

   chk_timer_read: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state_q == ST_IDLE && instr_i.valid && instr_i.op == instr_exec_pkg::OP_TIMER_MODE_READ
      |=> accumulator_o == $past(timer0_mode_reg_i) && !zero_flag_wr_o && $stable(zero_flag_o))
      else $error("timer mode read wrong");

   chk_xor_reg_wb: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state_q == ST_IDLE && instr_i.valid && instr_i.op == instr_exec_pkg::OP_XOR_REG && instr_i.dest_reg
      |=> reg_wr_o.en && reg_wr_o.data == ($past(acc_q) ^ $past(reg_rdata_i)) && $stable(accumulator_o))
      else $error("register xor write-back wrong");

   chk_xor_reg_acc: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state_q == ST_IDLE && instr_i.valid && instr_i.op == instr_exec_pkg::OP_XOR_REG && !instr_i.dest_reg
      |=> !reg_wr_o.en && accumulator_o == ($past(acc_q) ^ $past(reg_rdata_i)))
      else $error("register xor to accumulator wrong");

   chk_xor_imm: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state_q == ST_IDLE && instr_i.valid && instr_i.op == instr_exec_pkg::OP_XOR_IMM
      |=> accumulator_o == ($past(acc_q) ^ $past(instr_i.imm)) && zero_flag_wr_o)
      else $error("immediate xor wrong");

   chk_zero_flag: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      zero_flag_wr_o && !reg_wr_o.en |-> zero_flag_o == (accumulator_o == instr_exec_pkg::ZERO_BYTE))
      else $error("zero flag mismatch");

   // Write-back results carry their own zero flag, the accumulator stays as it was
   chk_xor_reg_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      zero_flag_wr_o && reg_wr_o.en |-> zero_flag_o == (reg_wr_o.data == instr_exec_pkg::ZERO_BYTE))
      else $error("register xor zero flag wrong");

   chk_xor_reg_addr: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state_q == ST_IDLE && instr_i.valid && instr_i.op == instr_exec_pkg::OP_XOR_REG && instr_i.dest_reg
      |=> reg_wr_o.addr == $past(instr_i.reg_addr))
      else $error("register xor write address wrong");

   sequence s_table_wait;
      state_q == ST_ROM_WAIT;
   endsequence

   chk_table_busy: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      s_table_issue |=> busy_o ##1 !busy_o)
      else $error("table read busy window wrong");

   // An instruction offered during the ROM wait must leave no trace
   chk_busy_refuse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      s_table_issue ##1 s_table_wait |=> !zero_flag_wr_o && !reg_wr_o.en && !rom_rd_o && !busy_o)
      else $error("instruction taken while busy");

   chk_rom_pulse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      rom_rd_o |=> !rom_rd_o)
      else $error("rom read strobe too long");

   chk_none_quiet: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state_q == ST_IDLE && instr_i.valid && instr_i.op == instr_exec_pkg::OP_NONE
      |=> !zero_flag_wr_o && !reg_wr_o.en && !rom_rd_o && $stable(accumulator_o))
      else $error("empty instruction changed state");

endmodule // table_read_xor_instr_exec

// ===== hdl/xor_unit.sv
// Exclusive-OR unit with zero detect
`timescale 1ns/1ns
module xor_unit (
   // Operands
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   // Result
   output logic [7:0] result_o,
   output logic zero_o
);

   always_comb begin
      result_o = a_i ^ b_i;
      zero_o = (result_o == instr_exec_pkg::ZERO_BYTE);
   end

endmodule // xor_unit

// ===== tb/test_table_read_xor_instr_exec.sv
// Self-checking bench for the table read / xor instruction executor
`timescale 1ns/1ns
module test_table_read_xor_instr_exec;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   instr_exec_pkg::instr_t instr_i = '0;
   logic busy_o;
   logic [2:0] table_high_pointer_i = 3'h0;
   logic [7:0] timer0_mode_reg_i = 8'h00;
   logic [7:0] reg_rdata_i = 8'h00;
   logic rom_rd_o;
   logic [10:0] rom_addr_o;
   logic [13:0] rom_data_i = 14'h0000;
   logic [6:0] reg_raddr_o;
   instr_exec_pkg::reg_wr_t reg_wr_o;
   logic [7:0] accumulator_o;
   logic [5:0] table_high_data_o;
   logic zero_flag_o;
   logic zero_flag_wr_o;
   int fails = 0;
   int n_tests = 0;

   table_read_xor_instr_exec i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .instr_i(instr_i),
      .busy_o(busy_o), .table_high_pointer_i(table_high_pointer_i), .timer0_mode_reg_i(timer0_mode_reg_i),
      .reg_rdata_i(reg_rdata_i), .rom_rd_o(rom_rd_o), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
      .reg_raddr_o(reg_raddr_o), .reg_wr_o(reg_wr_o), .accumulator_o(accumulator_o),
      .table_high_data_o(table_high_data_o), .zero_flag_o(zero_flag_o), .zero_flag_wr_o(zero_flag_wr_o));

   always #5 sys_clk_i = ~sys_clk_i;

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Presents one instruction for a single taking edge, returns just after that edge
   task automatic issue(input instr_exec_pkg::opcode_t op, input logic [6:0] ra, input logic d,
                        input logic [7:0] imm, input logic [7:0] tm, input logic [7:0] rd);
      @(posedge sys_clk_i);
      instr_i <= '{valid: 1'b1, op: op, reg_addr: ra, dest_reg: d, imm: imm};
      timer0_mode_reg_i <= tm;
      reg_rdata_i <= rd;
      @(posedge sys_clk_i);
      instr_i.valid <= 1'b0;
      #1;
   endtask

   task automatic t_timer_read();
      logic z;
      z = zero_flag_o;
      issue(instr_exec_pkg::OP_TIMER_MODE_READ, 7'h00, 1'b0, 8'h00, 8'h55, 8'h00);
      check(accumulator_o, 8'h55);
      check(zero_flag_wr_o, 1'b0);
      check(zero_flag_o, z);
   endtask

   task automatic t_xor_reg();
      issue(instr_exec_pkg::OP_TIMER_MODE_READ, 7'h00, 1'b0, 8'h00, 8'hF0, 8'h00);
      issue(instr_exec_pkg::OP_XOR_REG, 7'h7F, 1'b1, 8'h00, 8'h00, 8'hA5);
      check(reg_wr_o, {1'b1, 7'h7F, 8'h55});
      check(reg_raddr_o, 7'h7F);
      check(accumulator_o, 8'hF0);
      check({zero_flag_wr_o, zero_flag_o}, 2'h2);
      issue(instr_exec_pkg::OP_XOR_REG, 7'h00, 1'b0, 8'h00, 8'h00, 8'hF0);
      check(reg_wr_o.en, 1'b0);
      check(accumulator_o, 8'h00);
      check({zero_flag_wr_o, zero_flag_o}, 2'h3);
   endtask

   task automatic t_xor_imm();
      issue(instr_exec_pkg::OP_TIMER_MODE_READ, 7'h00, 1'b0, 8'h00, 8'hF0, 8'h00);
      issue(instr_exec_pkg::OP_XOR_IMM, 7'h00, 1'b0, 8'hA5, 8'h00, 8'h00);
      check(accumulator_o, 8'h55);
      check({zero_flag_wr_o, zero_flag_o}, 2'h2);
      issue(instr_exec_pkg::OP_XOR_IMM, 7'h00, 1'b0, 8'h55, 8'h00, 8'h00);
      check(accumulator_o, 8'h00);
      check({zero_flag_wr_o, zero_flag_o}, 2'h3);
   endtask

   // Table read with the pointer driven to the given value, word returned on the following cycle
   task automatic t_table(input logic [2:0] ptr, input logic [7:0] acc, input logic [13:0] word);
      issue(instr_exec_pkg::OP_TIMER_MODE_READ, 7'h00, 1'b0, 8'h00, acc, 8'h00);
      @(posedge sys_clk_i);
      table_high_pointer_i <= ptr;
      rom_data_i <= word;
      issue(instr_exec_pkg::OP_TABLE_READ, 7'h00, 1'b0, 8'h00, 8'h00, 8'h00);
      check({rom_rd_o, busy_o}, 2'h3);
      check(rom_addr_o, {ptr, acc});
      @(posedge sys_clk_i);
      #1;
      check(accumulator_o, word[7:0]);
      check(table_high_data_o, word[13:8]);
      check({rom_rd_o, busy_o}, 2'h0);
   endtask

   // Empty instruction, then an immediate xor offered while the table read is busy
   task automatic t_refused();
      issue(instr_exec_pkg::OP_NONE, 7'h00, 1'b0, 8'hFF, 8'h00, 8'h00);
      check({zero_flag_wr_o, accumulator_o}, {1'b0, 8'h55});
      @(posedge sys_clk_i);
      table_high_pointer_i <= 3'h1;
      rom_data_i <= 14'h3FC3;
      @(posedge sys_clk_i);
      instr_i <= '{valid: 1'b1, op: instr_exec_pkg::OP_TABLE_READ, reg_addr: 7'h00, dest_reg: 1'b0, imm: 8'h00};
      @(posedge sys_clk_i);
      instr_i <= '{valid: 1'b1, op: instr_exec_pkg::OP_XOR_IMM, reg_addr: 7'h00, dest_reg: 1'b0, imm: 8'hFF};
      @(posedge sys_clk_i);
      instr_i.valid <= 1'b0;
      #1;
      check(accumulator_o, 8'hC3);
      check(table_high_data_o, 6'h3F);
      check(zero_flag_wr_o, 1'b0);
   endtask

   initial begin
      repeat (4) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      #1;
      check(accumulator_o, instr_exec_pkg::ACC_RESET);
      check(table_high_data_o, instr_exec_pkg::HIGH_DATA_RESET);
      t_timer_read();
      t_xor_reg();
      t_timer_read();
      t_xor_imm();
      t_table(3'h2, 8'h34, 14'h35AA);
      t_table(3'h7, 8'hFF, 14'h2A55);
      t_refused();
      print_verdict();
   end

   initial begin
      #20000;
      fails++;
      print_verdict();
   end
endmodule // test_table_read_xor_instr_exec
